// >>> core/pio_target_pkg.sv
// Shared constants and types of the programmed I/O completer target
`default_nettype none
package pio_target_pkg;
	// Completer request descriptor field positions
	localparam int DESC_W    = 128;
	localparam int ADDR_LSB  = 2;
	localparam int DWCNT_LSB = 64;
	localparam int TYPE_LSB  = 75;
	localparam int REQID_LSB = 80;
	localparam int TAG_LSB   = 96;
	localparam int BAR_LSB   = 112;
	// Request type codes
	localparam logic [3:0] REQ_MEM_RD = 4'h0;
	localparam logic [3:0] REQ_MEM_WR = 4'h1;
	localparam logic [3:0] REQ_IO_RD  = 4'h2;
	localparam logic [3:0] REQ_IO_WR  = 4'h3;
	// Window identifiers as presented by the endpoint core
	localparam logic [2:0] BAR_MEM32    = 3'h0;
	localparam logic [2:0] BAR_MEM64    = 3'h1;
	localparam logic [2:0] BAR_EROM     = 3'h6;
	localparam logic [2:0] BAR_DW_SPACE = 3'h1;
	localparam logic [2:0] BAR_MAGIC    = 3'h0;
	// Local memory regions of address-aligned mode
	localparam logic [1:0] IO_SPACE_REGION      = 2'h0;
	localparam logic [1:0] MEM32_SPACE_REGION   = 2'h1;
	localparam logic [1:0] MEM64_SPACE_REGION   = 2'h2;
	localparam logic [1:0] EXPANSION_ROM_REGION = 2'h3;
	localparam int REGION_BYTES   = 2048;
	localparam int REGION_COUNT   = 4;
	localparam int DW_SPACE_BYTES = 2048;
	localparam logic [10:0] MAX_DW_LEN = 11'h100;
	// Magic writes that start outbound actions
	// Full offsets; the target compares them modulo its 2 KB window
	localparam logic [11:0] MAGIC_RD_ADDR   = 12'hEA8;
	localparam logic [31:0] MAGIC_RD_DATA   = 32'hAAAABBBB;
	localparam logic [11:0] MAGIC_INT_ADDR  = 12'hEEC;
	localparam logic [31:0] MAGIC_LEG_DATA  = 32'hCCCCDDDD;
	localparam logic [31:0] MAGIC_MSI_DATA  = 32'hEEEEFFFF;
	localparam logic [31:0] MAGIC_MSIX_DATA = 32'hDEADBEEF;
	localparam logic [2:0]  CPL_SC          = 3'h0;
	localparam int FIFO_DEPTH = 8;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WRITE,
		ST_DROP,
		ST_READ,
		ST_CPL
	} fsm_state_type;
endpackage
`default_nettype wire

// >>> core/pio_fifo.sv
// Synchronous valid/ready FIFO
`timescale 1ns/1ns
`default_nettype none
module pio_fifo #(
	parameter int WIDTH = 33,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
		$error("pio_fifo: DEPTH must be a power of two");
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	assign in_ready  = cnt_q != (AW+1)'(DEPTH);
	assign out_valid = cnt_q != '0;
	assign out_data  = mem[rd_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_q] <= in_data;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end
		else
		begin
			wr_q  <= wr_q + AW'(push);
			rd_q  <= rd_q + AW'(pop);
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

// >>> core/pcie_pio_completer_target.sv
// Programmed I/O completer target behind the endpoint request stream
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Aligned mode: four 2 KB regions, 8 KB
// - Aligned mode: single-dword mem and I/O only
// - Dword mode: window 001 (mem64) requests up to 256 dwords
// - Window taken from descriptor bits 114:112
// - Aligned reads complete with exactly one dword
// - I/O writes get successful completion without data
// - Dword mode: one 2048-byte stream-wide memory
// - Dword mode read completion length equals request
// - Magic write EA8/AAAABBBB starts host read
// - Magic write EEC/CCCCDDDD raises legacy interrupt
// - Magic write EEC/EEEEFFFF raises MSI
// - Magic write EEC/DEADBEEF raises MSI-X
// - Writes store payload at addressed location
// - Each region dual-port; core reports hit region
// - Window codes: 000 mem32, 001 mem64, 110 ROM
// - Extra windows of a kind get no completion
// - Addresses beyond 2 KB wrap onto memory
// - I/O requests served only in aligned mode
// - Aligned multi-dword mem request consumed, then dropped
// - Dword mode: consume whole request before completing
// - Ready held low during read access and completion
module pcie_pio_completer_target
	import pio_target_pkg::*;
#(
	parameter int         DATA_W    = 128,
	parameter bit         IO_BAR_EN = 1'b0,
	parameter logic [2:0] IO_BAR_ID = 3'h2
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              dword_aligned_mode,
	input  wire logic [DATA_W-1:0] cq_tdata,
	input  wire logic              cq_tvalid,
	input  wire logic              cq_tlast,
	output logic                   completer_request_ready,
	output logic                   cc_hdr_valid,
	input  wire logic              cc_hdr_ready,
	output logic      [15:0]       cc_requester_id,
	output logic      [7:0]        cc_tag,
	output logic      [6:0]        cc_lower_addr,
	output logic      [10:0]       cc_dword_count,
	output logic      [12:0]       cc_byte_count,
	output logic      [2:0]        cc_status,
	output logic                   cc_with_data,
	output logic                   cc_data_valid,
	input  wire logic              cc_data_ready,
	output logic      [DATA_W-1:0] cc_data,
	output logic                   cc_data_last,
	output logic                   host_read_start,
	output logic                   legacy_intr_req,
	output logic                   msi_req,
	output logic                   msix_req
);
	localparam int LANES  = DATA_W / 32;
	localparam int LG     = $clog2(LANES);
	localparam int RDW    = REGION_BYTES / 4;
	localparam int WDEPTH = DW_SPACE_BYTES * 8 / DATA_W;
	localparam logic [10:0] LANES_W = 11'(LANES);
	if (DATA_W < DESC_W || DATA_W > 512 || (DATA_W & (DATA_W - 1)) != 0)
		$error("DATA_W must be a power of two from 128 to 512");

	fsm_state_type state_q;
	// One array per region set; one port writes and the other reads, independently
	logic [31:0]             mem_aa [REGION_COUNT*RDW];
	logic [LANES-1:0][31:0]  mem_dw [WDEPTH];
	logic [1:0]  region_q;
	logic [2:0]  bar_q;
	logic        is_io_q;
	logic        first_q;
	logic [8:0]  dw_ptr_q;
	logic [10:0] left_q;
	logic [LG-1:0] lane0_q;
	logic        hdr_valid_q;

	// Descriptor fields, meaningful on the first beat only
	logic [3:0]  d_type;
	logic [2:0]  d_bar;
	logic [10:0] d_dwcnt;
	logic        d_rd;
	logic        d_io;
	logic        d_mem;
	logic        d_ok;
	logic [1:0]  d_region;
	logic        beat;
	logic        idle_beat;

	assign d_type  = cq_tdata[TYPE_LSB +: 4];
	assign d_bar   = cq_tdata[BAR_LSB +: 3];
	assign d_dwcnt = cq_tdata[DWCNT_LSB +: 11];
	assign d_rd    = d_type == REQ_MEM_RD || d_type == REQ_IO_RD;
	assign d_io    = d_type == REQ_IO_RD || d_type == REQ_IO_WR;
	assign d_mem   = d_type == REQ_MEM_RD || d_type == REQ_MEM_WR;
	assign beat    = cq_tvalid && completer_request_ready;
	assign idle_beat = beat && state_q == ST_IDLE;

	always_comb
	begin
		d_region = MEM32_SPACE_REGION;
		d_ok     = 1'b0;
		if (dword_aligned_mode)
			// Only mem requests in the single space qualify
			d_ok = d_mem && d_bar == BAR_DW_SPACE && d_dwcnt != '0
				&& d_dwcnt <= MAX_DW_LEN;
		else if (d_io)
		begin
			d_region = IO_SPACE_REGION;
			d_ok = IO_BAR_EN && d_bar == IO_BAR_ID;
		end
		else if (d_mem && d_dwcnt == 11'h001)
		begin
			unique case (d_bar)
				BAR_MEM32:
					d_ok = 1'b1;
				BAR_MEM64:
				begin
					d_region = MEM64_SPACE_REGION;
					d_ok = 1'b1;
				end
				BAR_EROM:
				begin
					d_region = EXPANSION_ROM_REGION;
					d_ok = 1'b1;
				end
				default:
					d_ok = 1'b0;
			endcase
		end
	end

	// Stall requests while memory or completion work is pending
	assign completer_request_ready = state_q == ST_IDLE
		|| state_q == ST_WRITE || state_q == ST_DROP;

	// Dword address of each lane; the sum wraps inside the space
	logic [8-LG:0] lane_word [LANES];
	logic [LG-1:0] lane_pos  [LANES];
	for (genvar g = 0; g < LANES; g++)
	begin
		assign {lane_word[g], lane_pos[g]} = dw_ptr_q + 9'(g);
	end

	// Read data packing toward the completion FIFO
	logic              push_valid;
	logic              push_ready;
	logic              push_last;
	logic [DATA_W-1:0] push_data;
	logic              push;

	always_comb
	begin
		push_data = '0;
		push_last = 1'b1;
		if (!dword_aligned_mode)
			push_data[31:0] = mem_aa[{region_q, dw_ptr_q}];
		else
		begin
			push_last = left_q <= LANES_W;
			for (int l = 0; l < LANES; l++)
			begin
				if (11'(l) < left_q)
					push_data[l*32 +: 32] =
						mem_dw[lane_word[l]][lane_pos[l]];
			end
		end
	end

	assign push_valid = state_q == ST_READ;
	assign push       = push_valid && push_ready;

	pio_fifo #(
		.WIDTH (DATA_W + 1),
		.DEPTH (FIFO_DEPTH)
	) u_cpl_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (push_valid),
		.in_ready  (push_ready),
		.in_data   ({push_last, push_data}),
		.out_valid (cc_data_valid),
		.out_ready (cc_data_ready),
		.out_data  ({cc_data_last, cc_data})
	);

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			state_q <= ST_IDLE;
		else
			unique case (state_q)
				ST_IDLE:
					if (beat)
					begin
						if (!d_ok)
							state_q <= cq_tlast ? ST_IDLE : ST_DROP;
						else if (d_rd)
							state_q <= ST_READ;
						else
							state_q <= cq_tlast ? ST_IDLE : ST_WRITE;
					end
				ST_WRITE:
					if (beat && cq_tlast)
						state_q <= is_io_q ? ST_CPL : ST_IDLE;
				ST_DROP:
					if (beat && cq_tlast)
						state_q <= ST_IDLE;
				ST_READ:
					if (push && push_last)
						state_q <= ST_CPL;
				ST_CPL:
					if (!hdr_valid_q && !cc_data_valid)
						state_q <= ST_IDLE;
			endcase
	end

	// Request context and walking pointers
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			region_q <= MEM32_SPACE_REGION;
			bar_q    <= '0;
			is_io_q  <= 1'b0;
			first_q  <= 1'b0;
			dw_ptr_q <= '0;
			left_q   <= '0;
			lane0_q  <= '0;
		end
		else if (idle_beat)
		begin
			region_q <= d_region;
			bar_q    <= d_bar;
			is_io_q  <= d_io;
			first_q  <= 1'b1;
			// Upper address bits drop so large windows wrap
			dw_ptr_q <= cq_tdata[ADDR_LSB +: 9];
			left_q   <= d_dwcnt;
			lane0_q  <= cq_tdata[ADDR_LSB +: LG];
		end
		else if ((state_q == ST_WRITE && beat) || push)
		begin
			first_q  <= 1'b0;
			dw_ptr_q <= dw_ptr_q + 9'(LANES);
			left_q   <= left_q > LANES_W ? left_q - LANES_W : '0;
		end
	end

	// Payload store
	logic [31:0] first_dw;
	assign first_dw = dword_aligned_mode ? cq_tdata[31:0]
		: cq_tdata[lane0_q*32 +: 32];

	always_ff @(posedge clk)
	begin
		if (state_q == ST_WRITE && beat)
		begin
			if (!dword_aligned_mode && first_q)
				mem_aa[{region_q, dw_ptr_q}] <= first_dw;
			else if (dword_aligned_mode)
				for (int l = 0; l < LANES; l++)
				begin
					if (11'(l) < left_q)
						mem_dw[lane_word[l]][lane_pos[l]]
							<= cq_tdata[l*32 +: 32];
				end
		end
	end

	// Magic writes into the first window start outbound actions
	logic magic_hit;
	logic [10:0] waddr;
	assign waddr = {dw_ptr_q, 2'b00};
	assign magic_hit = state_q == ST_WRITE && beat && first_q
		&& bar_q == BAR_MAGIC;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			host_read_start <= 1'b0;
			legacy_intr_req <= 1'b0;
			msi_req         <= 1'b0;
			msix_req        <= 1'b0;
		end
		else
		begin
			host_read_start <= magic_hit && waddr == MAGIC_RD_ADDR[10:0]
				&& first_dw == MAGIC_RD_DATA;
			legacy_intr_req <= magic_hit && waddr == MAGIC_INT_ADDR[10:0]
				&& first_dw == MAGIC_LEG_DATA;
			msi_req <= magic_hit && waddr == MAGIC_INT_ADDR[10:0]
				&& first_dw == MAGIC_MSI_DATA;
			msix_req <= magic_hit && waddr == MAGIC_INT_ADDR[10:0]
				&& first_dw == MAGIC_MSIX_DATA;
		end
	end

	// Completion header, held until the partner takes it
	assign cc_hdr_valid = hdr_valid_q;
	assign cc_status    = CPL_SC;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			hdr_valid_q <= 1'b0;
		else if (idle_beat && d_ok && d_rd)
			hdr_valid_q <= 1'b1;
		else if (state_q == ST_WRITE && beat && cq_tlast && is_io_q)
			hdr_valid_q <= 1'b1;
		else if (cc_hdr_ready)
			hdr_valid_q <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cc_requester_id <= '0;
			cc_tag          <= '0;
			cc_lower_addr   <= '0;
			cc_dword_count  <= '0;
			cc_byte_count   <= '0;
			cc_with_data    <= 1'b0;
		end
		else if (idle_beat)
		begin
			cc_requester_id <= cq_tdata[REQID_LSB +: 16];
			cc_tag          <= cq_tdata[TAG_LSB +: 8];
			cc_lower_addr   <= cq_tdata[6:0];
			cc_dword_count  <= d_dwcnt;
			cc_byte_count   <= {d_dwcnt, 2'b00};
			cc_with_data    <= d_rd;
		end
	end

	// Helper: dwords pushed for the current read completion
	logic [11:0] pushed_q;
	always_ff @(posedge clk)
	begin
		if (!rst_n || idle_beat)
			pushed_q <= '0;
		else if (push)
			pushed_q <= pushed_q + (dword_aligned_mode ? 12'(LANES) : 12'h001);
	end

	a_ready_stall: assert property (@(posedge clk) disable iff (!rst_n)
		cc_hdr_valid |-> !completer_request_ready)
		else $error("request ready high while completion pending");

	a_hdr_hold: assert property (@(posedge clk) disable iff (!rst_n)
		cc_hdr_valid && !cc_hdr_ready |=> cc_hdr_valid && $stable(cc_tag))
		else $error("completion header dropped before taken");

	a_aa_read_cpl: assert property (@(posedge clk) disable iff (!rst_n)
		idle_beat && d_ok && d_rd && !dword_aligned_mode
		|=> cc_hdr_valid && cc_with_data && cc_dword_count == 11'h001
		&& cc_tag == $past(cq_tdata[TAG_LSB +: 8]))
		else $error("aligned read completion wrong");

	a_io_wr_cpl: assert property (@(posedge clk) disable iff (!rst_n)
		state_q == ST_WRITE && beat && cq_tlast && is_io_q
		|=> cc_hdr_valid && !cc_with_data && cc_status == CPL_SC)
		else $error("I/O write completion missing");

	a_multi_drop: assert property (@(posedge clk) disable iff (!rst_n)
		idle_beat && !dword_aligned_mode && d_mem && d_dwcnt > 11'h001
		&& !cq_tlast |=> state_q == ST_DROP && !cc_hdr_valid)
		else $error("aligned multi-dword request not dropped");

	a_bar_unserved: assert property (@(posedge clk) disable iff (!rst_n)
		idle_beat && !dword_aligned_mode && d_mem && d_bar != BAR_MEM32
		&& d_bar != BAR_MEM64 && d_bar != BAR_EROM
		|=> !cc_hdr_valid [*2])
		else $error("unserved window produced a completion");

	a_dw_read_len: assert property (@(posedge clk) disable iff (!rst_n)
		push && push_last && dword_aligned_mode
		|-> pushed_q + 12'(LANES) >= {1'b0, cc_dword_count}
		&& pushed_q < {1'b0, cc_dword_count})
		else $error("dword-mode completion length mismatch");

	a_magic_read: assert property (@(posedge clk) disable iff (!rst_n)
		state_q == ST_WRITE && beat && first_q && bar_q == BAR_MAGIC
		&& waddr == MAGIC_RD_ADDR[10:0] && first_dw == MAGIC_RD_DATA
		|=> host_read_start ##1 !host_read_start)
		else $error("magic read start not pulsed");

	a_magic_msix: assert property (@(posedge clk) disable iff (!rst_n)
		msix_req |-> !msi_req && !legacy_intr_req
		&& $past(bar_q) == BAR_MAGIC)
		else $error("MSI-X request without its magic write");
endmodule
`default_nettype wire

// >>> tb/cc_sink.sv
// Completion-side sink standing in for the endpoint core
`timescale 1ns/1ns
`default_nettype none
module cc_sink (
	input  wire logic clk,
	input  wire logic stall,
	output logic      hdr_ready,
	output logic      data_ready
);
	logic [7:0] pat_q = 8'hA5;
	initial hdr_ready = 1'b0;
	initial data_ready = 1'b0;
	// Uneven pattern gives both prompt and slow acceptance
	always @(negedge clk)
	begin
		pat_q <= {pat_q[6:0], pat_q[7] ^ pat_q[5] ^ pat_q[4] ^ pat_q[3]};
		hdr_ready <= !stall && pat_q[0];
		data_ready <= !stall && (pat_q[1] | pat_q[2]);
	end
endmodule
`default_nettype wire

// >>> tb/pcie_pio_completer_target_test.sv
// Self-checking bench of the programmed I/O completer target
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; \
	$display("[FAIL] %0t %h %h", $time, (a), (b)); end end
module pcie_pio_completer_target_test;
	import pio_target_pkg::*;
	logic         clk = 1'b0;
	logic         rst_n = 1'b0;
	logic         mode = 1'b0;
	logic [127:0] tdata = '0;
	logic         tvalid = 1'b0;
	logic         tlast = 1'b0;
	logic         stall = 1'b0;
	logic [31:0]  rnd = 32'h00011A6C;
	logic [31:0]  pay[$];
	logic [58:0]  hq[$];
	logic [128:0] dq[$];
	logic [127:0] dm[$];
	logic [128:0] e;
	logic [127:0] m;
	logic [31:0]  wv[4];
	logic [2:0]   bars[4] = '{BAR_MEM32, BAR_MEM64, BAR_EROM, 3'h2};
	logic [11:0]  ma[6] = '{12'hEA8, 12'hEEC, 12'hEEC, 12'hEEC, 12'hEEC,
		12'hEEC};
	logic [31:0]  md[6] = '{MAGIC_RD_DATA, MAGIC_LEG_DATA, MAGIC_MSI_DATA,
		MAGIC_MSIX_DATA, MAGIC_LEG_DATA, 32'h1234ABCD};
	logic [2:0]   mb[6] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h0};
	int           pc[4] = '{0, 0, 0, 0};
	int           error_cnt = 0;
	int           compares = 0;
	int           k;
	wire logic    rdy, hv, hr, dv, dr, dl, wd, p_rd, p_leg, p_msi, p_msx;
	wire logic [15:0]  rid;
	wire logic [7:0]   tag;
	wire logic [6:0]   la;
	wire logic [10:0]  dwc;
	wire logic [12:0]  bc;
	wire logic [2:0]   st;
	wire logic [127:0] cd;

	initial forever #20 clk = ~clk;

	pcie_pio_completer_target #(.DATA_W(128), .IO_BAR_EN(1'b1),
		.IO_BAR_ID(3'h2)) dut (.clk(clk), .rst_n(rst_n),
		.dword_aligned_mode(mode), .cq_tdata(tdata), .cq_tvalid(tvalid),
		.cq_tlast(tlast), .completer_request_ready(rdy), .cc_hdr_valid(hv),
		.cc_hdr_ready(hr), .cc_requester_id(rid), .cc_tag(tag),
		.cc_lower_addr(la), .cc_dword_count(dwc), .cc_byte_count(bc),
		.cc_status(st), .cc_with_data(wd), .cc_data_valid(dv),
		.cc_data_ready(dr), .cc_data(cd), .cc_data_last(dl),
		.host_read_start(p_rd), .legacy_intr_req(p_leg), .msi_req(p_msi),
		.msix_req(p_msx));

	cc_sink far_end (.clk(clk), .stall(stall), .hdr_ready(hr),
		.data_ready(dr));

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	task automatic report_and_stop();
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Oldest note is matched against each completion as the sink takes it
	always @(posedge clk)
	begin
		if (hv === 1'b1 && hr === 1'b1)
		begin
			if (hq.size() == 0) `CHK(1'b0, 1'b1)
			else `CHK({rid, tag, la, dwc, bc, st, wd}, hq.pop_front())
		end
		if (dv === 1'b1 && dr === 1'b1)
		begin
			if (dq.size() == 0) `CHK(1'b0, 1'b1)
			else
			begin
				e = dq.pop_front();
				m = dm.pop_front();
				`CHK({dl, cd & m}, {e[128], e[127:0] & m})
			end
		end
		if (p_rd === 1'b1) pc[0]++;
		if (p_leg === 1'b1) pc[1]++;
		if (p_msi === 1'b1) pc[2]++;
		if (p_msx === 1'b1) pc[3]++;
	end

	task automatic beat(input logic [127:0] d, input logic l);
		int n;
		n = 0;
		@(negedge clk);
		tdata = d;
		tvalid = 1'b1;
		tlast = l;
		while (rdy !== 1'b1 && n < 500)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= 500)
		begin
			error_cnt++;
			report_and_stop();
		end
		@(posedge clk);
	endtask

	task automatic send(input logic [3:0] ty, input logic [2:0] bar,
		input logic [11:0] a, input int len, input bit rd, input bit cpl);
		logic [127:0] d;
		logic [128:0] ex;
		logic [127:0] mk;
		int i;
		int j;
		rnd = lfsr(rnd);
		d = '0;
		d[11:0] = a;
		d[74:64] = len[10:0];
		d[78:75] = ty;
		d[103:80] = rnd[23:0];
		d[114:112] = bar;
		if (cpl)
			hq.push_back({d[95:80], d[103:96], a[6:0], d[74:64],
				13'(len * 4), CPL_SC, rd});
		for (i = 0; rd && cpl && i < len; i += 4)
		begin
			ex = '0;
			mk = '0;
			for (j = 0; j < 4 && i + j < len; j++)
			begin
				ex[32*j +: 32] = pay[i+j];
				mk[32*j +: 32] = '1;
			end
			ex[128] = (i + 4 >= len);
			dq.push_back(ex);
			dm.push_back(mk);
		end
		beat(d, rd);
		for (i = 0; !rd && i < len; i += 4)
		begin
			d = '0;
			if (!mode)
				d[32*a[3:2] +: 32] = pay[0];
			else
				for (j = 0; j < 4 && i + j < len; j++)
					d[32*j +: 32] = pay[i+j];
			beat(d, mode ? i + 4 >= len : 1'b1);
			if (!mode) break;
		end
		@(negedge clk);
		tvalid = 1'b0;
		tlast = 1'b0;
	endtask

	task automatic drain();
		int n;
		for (n = 0; n < 3000 && (hq.size() || dq.size()); n++)
			@(negedge clk);
		if (n >= 3000)
		begin
			error_cnt++;
			report_and_stop();
		end
		repeat (6) @(negedge clk);
	endtask

	// Entered at time zero or at a falling edge: four rising edges in reset
	task automatic do_reset(input logic md);
		rst_n = 1'b0;
		mode = md;
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
	endtask

	initial
	begin
		do_reset(1'b0);
		// Same offset in all four regions, read back via the 2 KB alias
		for (k = 0; k < 4; k++)
		begin
			rnd = lfsr(rnd);
			wv[k] = rnd;
			pay = {wv[k]};
			send(k == 3 ? REQ_IO_WR : REQ_MEM_WR, bars[k], 12'h104, 1, 0,
				k == 3);
			drain();
		end
		for (k = 0; k < 4; k++)
		begin
			pay = {wv[k]};
			stall = (k == 0);
			send(k == 3 ? REQ_IO_RD : REQ_MEM_RD, bars[k], 12'h904, 1, 1,
				1);
			repeat (3) @(negedge clk);
			if (k == 0) `CHK(rdy, 1'b0)
			stall = 1'b0;
			drain();
		end
		pay = {wv[0]};
		send(REQ_MEM_RD, BAR_MEM32, 12'h104, 2, 1, 0);
		send(REQ_MEM_WR, BAR_MEM32, 12'h104, 2, 0, 0);
		send(REQ_MEM_RD, 3'h3, 12'h104, 1, 1, 0);
		send(REQ_MEM_RD, BAR_MEM32, 12'h104, 1, 1, 1);
		drain();
		for (k = 0; k < 6; k++)
		begin
			pay = {md[k]};
			send(REQ_MEM_WR, mb[k], ma[k], 1, 0, 0);
		end
		repeat (6) @(negedge clk);
		`CHK(pc[0], 1)
		`CHK(pc[1], 1)
		`CHK(pc[2], 1)
		`CHK(pc[3], 1)
		do_reset(1'b1);
		pay = {};
		for (k = 0; k < 256; k++)
		begin
			rnd = lfsr(rnd);
			pay.push_back(rnd);
		end
		send(REQ_MEM_WR, BAR_DW_SPACE, 12'h000, 256, 0, 0);
		// Long stall fills the completion buffer until it holds back
		stall = 1'b1;
		send(REQ_MEM_RD, BAR_DW_SPACE, 12'h000, 256, 1, 1);
		repeat (20) @(negedge clk);
		stall = 1'b0;
		drain();
		pay = pay[4:6];
		send(REQ_MEM_RD, BAR_DW_SPACE, 12'h010, 3, 1, 1);
		send(REQ_MEM_RD, BAR_DW_SPACE, 12'h000, 257, 1, 0);
		send(REQ_MEM_RD, BAR_MEM32, 12'h000, 1, 1, 0);
		send(REQ_IO_RD, 3'h2, 12'h000, 1, 1, 0);
		drain();
		report_and_stop();
	end
endmodule
`default_nettype wire
